// file: test/gpio_port0_config_sva.sv
// Port-level assertions for the port-0 GPIO configuration bank
`timescale 1ns/1ps

module gpio_port0_check (
  input wire logic clk, // device clock
  input wire logic nrst, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [9:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [7:0] pin_in, // pad levels
  input wire logic [7:0] pin_out, // pad drive value
  input wire logic [7:0] pin_oe, // pad drive enable
  input wire logic [7:0] bank_select, // logical device
  input wire logic bank_reserved, // reserved selector code
  input wire logic [3:0] irq_channel, // routed channel
  input wire logic irq // level interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================
  // Helper logic
  logic [7:0] pin_prev;
  logic [2:0] calm_cnt;
  logic dir_hit;
  // Pad levels must sit still long enough to cross both sync flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_prev <= 8'h00;
      calm_cnt <= 3'h0;
      dir_hit <= 1'b0;
    end else begin
      pin_prev <= pin_in;
      calm_cnt <= (pin_in != pin_prev) ? 3'h0 :
        ((calm_cnt == 3'h7) ? calm_cnt : calm_cnt + 3'h1);
      dir_hit <= psel && penable && pwrite && pstrb[0] &&
        paddr == 10'h380 && bank_select == 8'h06;
    end
  end

  // ==========================================
  // Assertions
  sequence sel_wr;
    psel && penable && pwrite && pstrb[0] && paddr == 10'h01C;
  endsequence
  sequence gpio_wr(logic [9:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == a &&
      bank_select == 8'h06;
  endsequence

  bank_write_a: assert property (
    sel_wr |=> bank_select == $past(pwdata[7:0]))
    else $error("selector not loaded");
  bank_code_a: assert property (
    bank_reserved == !(bank_select inside {8'h00, 8'h01, 8'h02,
      8'h03, 8'h04, 8'h06, 8'h0A}))
    else $error("reserved flag wrong");
  route_write_a: assert property (
    gpio_wr(10'h1C0) |=> irq_channel == $past(pwdata[3:0]))
    else $error("route not loaded");
  route_read_a: assert property (
    psel && penable && !pwrite && paddr == 10'h1C0 |-> prdata[7:4] == 4'h0)
    else $error("route upper bits not zero");
  dir_write_a: assert property (
    gpio_wr(10'h380) |=> pin_oe == $past(pwdata[7:0]))
    else $error("direction not applied");
  dir_cause_a: assert property (
    $changed(pin_oe) |-> dir_hit)
    else $error("direction changed unasked");
  dir_reset_a: assert property (
    $rose(nrst) |-> pin_oe == 8'h00)
    else $error("pins not inputs after reset");
  level_read_a: assert property (
    psel && penable && !pwrite && paddr == 10'h388 &&
      bank_select == 8'h06 && calm_cnt >= 3'h5 && $stable(pin_in)
      |-> prdata[7:0] == pin_in)
    else $error("pin level read wrong");
endmodule // gpio_port0_check

// file: test/gpio_port0_config_tb.sv
// Self-checking bench for the port-0 GPIO configuration bank
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end end

module gpio_port0_config_tb;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic bank_reserved, irq, errv;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb, irq_channel;
  logic [7:0] pin_in, pin_out, pin_oe, bank_select, ext_level;
  int error_cnt, n_compared;
  int pw [4] = '{10, 20, 40, 80};

  // ==========================================
  // Bus tasks
  task automatic summarize;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [9:0] a,
      input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask
  task automatic rd(input logic [7:0] i);
    apb(1'b0, {i, 2'b00}, 8'h00);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] idx [9] = '{8'h70, 8'hE0, 8'hE1, 8'hE3, 8'hE4, 8'hE5,
      8'hE6, 8'hE8, 8'hE9};
    rd(8'h07);
    `CHK("selector", 32'h0, rdv)
    wr(8'h07, 8'h06);
    foreach (idx[k]) begin
      rd(idx[k]);
      `CHK("reset value", 32'h0, rdv)
    end
  endtask
  task automatic t_bank;
    logic [7:0] code [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0A,
      8'h05, 8'h0B, 8'hFF};
    foreach (code[k]) begin
      wr(8'h07, code[k]);
      `CHK("bank", code[k], bank_select)
      `CHK("reserved", k > 5, bank_reserved)
      wr(8'hE0, 8'hFF);
      rd(8'hE0);
      `CHK("other bank read", 32'h0, rdv)
    end
    wr(8'h07, 8'h06);
    `CHK("gpio bank", 1'b0, bank_reserved)
    `CHK("direction kept", 8'h00, pin_oe)
  endtask
  task automatic t_route;
    wr(8'h70, 8'hFF);
    rd(8'h70);
    `CHK("route read", 32'h0F, rdv)
    `CHK("channel", 4'hF, irq_channel)
  endtask
  task automatic t_level;
    wr(8'hE0, 8'h01);
    wr(8'hE1, 8'h01);
    settle();
    `CHK("oe", 8'h01, pin_oe)
    `CHK("steady high", 1'b1, pin_out[0])
    rd(8'hE2);
    `CHK("driven pad", 1'b1, rdv[0])
    pstrb <= 4'h0;
    wr(8'hE1, 8'h00);
    pstrb <= 4'hF;
    settle();
    `CHK("strobe off", 1'b1, pin_out[0])
    wr(8'hE1, 8'h00);
    settle();
    `CHK("drive low", 1'b0, pin_out[0])
  endtask
  task automatic t_pulse;
    int n;
    int k;
    logic pol;
    wr(8'hE3, 8'h01);
    for (int c = 0; c < 4; c++) begin
      pol = c[0];
      wr(8'hE4, c[7:0]);
      wr(8'hE6, {7'h00, pol});
      wr(8'hF1, {7'h00, c != 3});
      settle();
      `CHK("idle level", !pol, pin_out[0])
      n = 0;
      fork
        begin
          wr(8'hE1, 8'h01);
          wr(8'hE1, 8'h01);
        end
        begin
          for (k = 0; k < 20 && pin_out[0] !== pol; k++) @(negedge clk);
          while (pin_out[0] === pol && n < 300) begin
            n++;
            @(negedge clk);
          end
        end
      join
      @(posedge clk);
      `CHK("pulse width", pw[c], n)
      rd(8'hE1);
      `CHK("auto clear", 32'h0, rdv)
      rd(8'hF0);
      `CHK("done flag", 32'h1, rdv)
      `CHK("done irq", c != 3, irq)
      wr(8'hF2, 8'h01);
      settle();
      `CHK("irq cleared", 1'b0, irq)
      `CHK("no rearm", !pol, pin_out[0])
    end
  endtask
  task automatic t_upper;
    int n;
    // Low pulse on pin 4, idle level matches the board level
    wr(8'hE3, 8'h11);
    wr(8'hE5, 8'h01);
    wr(8'hE0, 8'h11);
    wr(8'hE1, 8'h10);
    n = 0;
    for (int k = 0; k < 300; k++) begin
      @(posedge clk);
      if (pin_out[4] === 1'b0) n++;
    end
    `CHK("upper pin width", pw[1], n)
  endtask
  task automatic t_input;
    wr(8'hE0, 8'h00);
    wr(8'hE9, 8'hFF);
    settle();
    rd(8'hE2);
    `CHK("pad levels", 32'h5A, rdv)
    wr(8'hE2, 8'hFF);
    rd(8'hE2);
    `CHK("status read only", 32'h5A, rdv)
    wr(8'hE8, 8'h80);
    ext_level <= 8'hDA;
    repeat (6) @(posedge clk);
    `CHK("change irq", 1'b1, irq)
    rd(8'hE9);
    `CHK("change flag", 32'h80, rdv)
    wr(8'hE9, 8'h80);
    settle();
    `CHK("flag cleared", 1'b0, irq)
    wr(8'hE8, 8'h00);
    ext_level <= 8'h5A;
    repeat (6) @(posedge clk);
    `CHK("masked", 1'b0, irq)
    rd(8'hE7);
    `CHK("unmapped", 1'b1, errv)
    apb(1'b0, 10'h381, 8'h00);
    `CHK("misaligned", 1'b1, errv)
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 10'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    ext_level = 8'h5A;
    error_cnt = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_bank();
    t_route();
    t_level();
    t_pulse();
    t_upper();
    t_input();
    summarize();
  end
  always #25 clk = ~clk;

  gpio_port0_config #(.PW0_CYC(10), .PW1_CYC(20), .PW2_CYC(40),
    .PW3_CYC(80), .CNT_W(21)) dut_u (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .bank_select(bank_select), .bank_reserved(bank_reserved),
    .irq_channel(irq_channel), .irq(irq));
  pin_board board_u (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .pin_in(pin_in));
endmodule // gpio_port0_config_tb

bind gpio_port0_config gpio_port0_check check_u (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .bank_select(bank_select), .bank_reserved(bank_reserved),
  .irq_channel(irq_channel), .irq(irq));

// file: test/pin_board.sv
// Board side of the eight shared port-0 pins
`timescale 1ns/1ps

module pin_board (
  input wire logic [7:0] pin_out, // device drive value
  input wire logic [7:0] pin_oe, // device drive enable
  input wire logic [7:0] ext_level, // level the board imposes
  output logic [7:0] pin_in // pad level back to the device
);
  // Driven pads read back their drive, the rest the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_board

// file: verilog/gpio_port0_config.sv
// Port-0 GPIO configuration bank with APB register access
//
// Operation
// - Selector at 07h; 06h picks GPIO bank.
// - Other selector codes pick other banks, else reserved.
// - 70h low nibble routes interrupt, upper reads zero.
// - E0h direction per pin, one is output, reset zero.
// - E1h output value, zero drives low.
// - Level mode: one drives steady high.
// - Pulse mode: writing one emits one pulse.
// - Value bit clears itself after the pulse.
// - E2h read-only sampled pin levels.
// - Status reports pad level for shared pins.
// - E3h selects level or pulse mode.
// - E4h/E5h two-bit width: 500us,1ms,20ms,100ms.
// - E6h polarity: zero low pulse, one high.
// - E8h change enables, E9h change flags W1C.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

module gpio_port0_config #(
  parameter int unsigned PW0_CYC = gpio_port_pkg::PW_500US_CYC,
  parameter int unsigned PW1_CYC = gpio_port_pkg::PW_1MS_CYC,
  parameter int unsigned PW2_CYC = gpio_port_pkg::PW_20MS_CYC,
  parameter int unsigned PW3_CYC = gpio_port_pkg::PW_100MS_CYC,
  parameter int unsigned CNT_W = gpio_port_pkg::PW_CNT_W
) (
  input wire logic clk, // 20 MHz device clock
  input wire logic nrst, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [gpio_port_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [7:0] pin_in, // pad levels, asynchronous
  output logic [7:0] pin_out, // pad drive value
  output logic [7:0] pin_oe, // pad output enable
  output logic [7:0] bank_select, // current logical device
  output logic bank_reserved, // selector holds a reserved code
  output logic [3:0] irq_channel, // routed interrupt channel
  output logic irq // level interrupt, active high
);

  localparam int unsigned N = gpio_port_pkg::PIN_N;
  localparam int unsigned AW = gpio_port_pkg::ADDR_W;

  initial begin
    if (PW0_CYC < 2 || PW1_CYC < 2 || PW2_CYC < 2 || PW3_CYC < 2)
      $error("gpio_port0_config: pulse counts must be at least 2");
    if (PW3_CYC >= (64'd1 << CNT_W) || PW2_CYC >= (64'd1 << CNT_W) ||
        PW1_CYC >= (64'd1 << CNT_W) || PW0_CYC >= (64'd1 << CNT_W))
      $error("gpio_port0_config: CNT_W too narrow for pulse counts");
  end

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] width_count(
    input logic [1:0] sel
  );
    logic [CNT_W-1:0] c;
    c = CNT_W'(PW0_CYC);
    case (sel)
      2'h0: c = CNT_W'(PW0_CYC);
      2'h1: c = CNT_W'(PW1_CYC);
      2'h2: c = CNT_W'(PW2_CYC);
      2'h3: c = CNT_W'(PW3_CYC);
      default: c = CNT_W'(PW0_CYC);
    endcase
    return c;
  endfunction

  function automatic logic is_reserved(input logic [7:0] sel);
    logic r;
    r = 1'b1;
    case (sel)
      gpio_port_pkg::DEV_FLOPPY, gpio_port_pkg::DEV_SERIAL1,
      gpio_port_pkg::DEV_SERIAL2, gpio_port_pkg::DEV_PARALLEL,
      gpio_port_pkg::DEV_MONITOR, gpio_port_pkg::DEV_GPIO,
      gpio_port_pkg::DEV_POWER_EVENT: r = 1'b0;
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  // Index is valid only on an aligned word address
  function automatic logic index_mapped(input logic [7:0] idx);
    logic m;
    m = 1'b0;
    case (idx)
      gpio_port_pkg::IDX_DEVICE_SELECT, gpio_port_pkg::IDX_IRQ_ROUTE,
      gpio_port_pkg::IDX_DIRECTION, gpio_port_pkg::IDX_OUT_VALUE,
      gpio_port_pkg::IDX_PIN_LEVEL, gpio_port_pkg::IDX_PULSE_MODE,
      gpio_port_pkg::IDX_WIDTH_LO, gpio_port_pkg::IDX_WIDTH_HI,
      gpio_port_pkg::IDX_POLARITY, gpio_port_pkg::IDX_CHANGE_IEN,
      gpio_port_pkg::IDX_CHANGE_FLAG, gpio_port_pkg::IDX_DONE_STATUS,
      gpio_port_pkg::IDX_DONE_ENABLE,
      gpio_port_pkg::IDX_DONE_CLEAR: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // ==========================================================
  // Pin synchroniser
  logic [7:0] sync1_reg, sync2_reg, level_prev_reg;
  // Zeroed chain would fake an edge on every high pad after reset
  logic [2:0] warm_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= gpio_port_pkg::RST_BYTE;
      sync2_reg <= gpio_port_pkg::RST_BYTE;
      level_prev_reg <= gpio_port_pkg::RST_BYTE;
      warm_reg <= 3'h0;
    end else begin
      sync1_reg <= pin_in;
      warm_reg <= {warm_reg[1:0], 1'b1};
      sync2_reg <= sync1_reg;
      level_prev_reg <= sync2_reg;
    end
  end

  // ==========================================================
  // Bus decode
  logic [7:0] idx;
  logic aligned, mapped, gpio_bank, bank_access, wr_en, wr_low;

  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped = aligned && index_mapped(idx);
  assign wr_en = psel && penable && pwrite && mapped;
  assign wr_low = wr_en && pstrb[0];
  assign pready = 1'b1;

  // ==========================================================
  // Configuration registers
  logic [7:0] select_reg, select_next;
  logic [7:0] route_reg, route_next;
  logic [7:0] dir_reg, dir_next;
  logic [7:0] val_reg, val_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] wlo_reg, wlo_next;
  logic [7:0] whi_reg, whi_next;
  logic [7:0] pol_reg, pol_next;
  logic [7:0] ien_reg, ien_next;
  logic [7:0] chg_reg, chg_next;
  logic [7:0] dstat_reg, dstat_next;
  logic [7:0] den_reg, den_next;
  logic [7:0] start, busy, done;
  logic [7:0] change_evt;
  logic [15:0] wsel;

  assign gpio_bank = (select_reg == gpio_port_pkg::DEV_GPIO);
  assign bank_access = (idx == gpio_port_pkg::IDX_DEVICE_SELECT) ||
                       gpio_bank;
  assign wsel = {whi_reg, wlo_reg};
  assign change_evt = {N{warm_reg[2]}} & ~dir_reg &
                      (sync2_reg ^ level_prev_reg);

  always_comb begin
    select_next = select_reg;
    route_next = route_reg;
    dir_next = dir_reg;
    val_next = val_reg;
    mode_next = mode_reg;
    wlo_next = wlo_reg;
    whi_next = whi_reg;
    pol_next = pol_reg;
    ien_next = ien_reg;
    chg_next = chg_reg;
    dstat_next = dstat_reg;
    den_next = den_reg;
    start = gpio_port_pkg::RST_BYTE;
    if (wr_low && bank_access) begin
      case (idx)
        gpio_port_pkg::IDX_DEVICE_SELECT: select_next = pwdata[7:0];
        gpio_port_pkg::IDX_IRQ_ROUTE:
          route_next = pwdata[7:0] & gpio_port_pkg::ROUTE_MASK;
        gpio_port_pkg::IDX_DIRECTION: dir_next = pwdata[7:0];
        gpio_port_pkg::IDX_OUT_VALUE: begin
          val_next = pwdata[7:0];
          start = pwdata[7:0] & dir_reg & mode_reg;
        end
        gpio_port_pkg::IDX_PULSE_MODE: mode_next = pwdata[7:0];
        gpio_port_pkg::IDX_WIDTH_LO: wlo_next = pwdata[7:0];
        gpio_port_pkg::IDX_WIDTH_HI: whi_next = pwdata[7:0];
        gpio_port_pkg::IDX_POLARITY: pol_next = pwdata[7:0];
        gpio_port_pkg::IDX_CHANGE_IEN: ien_next = pwdata[7:0];
        gpio_port_pkg::IDX_CHANGE_FLAG:
          chg_next = chg_reg & ~pwdata[7:0];
        gpio_port_pkg::IDX_DONE_ENABLE: den_next = pwdata[7:0];
        gpio_port_pkg::IDX_DONE_CLEAR:
          dstat_next = dstat_reg & ~pwdata[7:0];
        default: begin
          // Pin level and done status ignore writes
        end
      endcase
    end
    // Hardware clears value once a pulse ends
    val_next = val_next & ~done;
    // New events win over a clear in the same cycle
    chg_next = chg_next | change_evt;
    dstat_next = dstat_next | done;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      select_reg <= gpio_port_pkg::RST_BYTE;
      route_reg <= gpio_port_pkg::RST_BYTE;
      dir_reg <= gpio_port_pkg::RST_BYTE;
      val_reg <= gpio_port_pkg::RST_BYTE;
      mode_reg <= gpio_port_pkg::RST_BYTE;
      wlo_reg <= gpio_port_pkg::RST_BYTE;
      whi_reg <= gpio_port_pkg::RST_BYTE;
      pol_reg <= gpio_port_pkg::RST_BYTE;
      ien_reg <= gpio_port_pkg::RST_BYTE;
      chg_reg <= gpio_port_pkg::RST_BYTE;
      dstat_reg <= gpio_port_pkg::RST_BYTE;
      den_reg <= gpio_port_pkg::RST_BYTE;
    end else begin
      select_reg <= select_next;
      route_reg <= route_next;
      dir_reg <= dir_next;
      val_reg <= val_next;
      mode_reg <= mode_next;
      wlo_reg <= wlo_next;
      whi_reg <= whi_next;
      pol_reg <= pol_next;
      ien_reg <= ien_next;
      chg_reg <= chg_next;
      dstat_reg <= dstat_next;
      den_reg <= den_next;
    end
  end

  // ==========================================================
  // Pulse timers, one per pin
  for (genvar i = 0; i < N; i++) begin : g_pin
    pulse_timer #(
      .CNT_W(CNT_W)
    ) u_timer (
      .clk(clk),
      .nrst(nrst),
      .start(start[i]),
      .term(width_count(wsel[2*i +: 2])),
      .busy(busy[i]),
      .done(done[i])
    );
  end

  // ==========================================================
  // Pad drive and interrupt, all registered
  logic [7:0] out_reg, out_next;
  logic irq_reg, irq_next;

  always_comb begin
    // Idle pulse-mode pin rests at the inactive level
    for (int i = 0; i < N; i++) begin
      if (mode_reg[i]) begin
        out_next[i] = busy[i] ? pol_reg[i] : ~pol_reg[i];
      end else begin
        out_next[i] = val_reg[i];
      end
    end
    irq_next = |(chg_reg & ien_reg) || |(dstat_reg & den_reg);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_reg <= gpio_port_pkg::RST_BYTE;
      irq_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      irq_reg <= irq_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = dir_reg;
  assign irq = irq_reg;
  assign irq_channel = route_reg[gpio_port_pkg::ROUTE_W-1:0];
  assign bank_select = select_reg;
  assign bank_reserved = is_reserved(select_reg);

  // ==========================================================
  // Read path, captured in the setup cycle
  logic [7:0] rd_byte;
  logic [31:0] prdata_reg, prdata_next;
  logic err_reg, err_next;

  always_comb begin
    rd_byte = gpio_port_pkg::RST_BYTE;
    if (bank_access) begin
      case (idx)
        gpio_port_pkg::IDX_DEVICE_SELECT: rd_byte = select_reg;
        gpio_port_pkg::IDX_IRQ_ROUTE: rd_byte = route_reg;
        gpio_port_pkg::IDX_DIRECTION: rd_byte = dir_reg;
        gpio_port_pkg::IDX_OUT_VALUE: rd_byte = val_reg;
        gpio_port_pkg::IDX_PIN_LEVEL: rd_byte = sync2_reg;
        gpio_port_pkg::IDX_PULSE_MODE: rd_byte = mode_reg;
        gpio_port_pkg::IDX_WIDTH_LO: rd_byte = wlo_reg;
        gpio_port_pkg::IDX_WIDTH_HI: rd_byte = whi_reg;
        gpio_port_pkg::IDX_POLARITY: rd_byte = pol_reg;
        gpio_port_pkg::IDX_CHANGE_IEN: rd_byte = ien_reg;
        gpio_port_pkg::IDX_CHANGE_FLAG: rd_byte = chg_reg;
        gpio_port_pkg::IDX_DONE_STATUS: rd_byte = dstat_reg;
        gpio_port_pkg::IDX_DONE_ENABLE: rd_byte = den_reg;
        default: rd_byte = gpio_port_pkg::RST_BYTE;
      endcase
    end
    prdata_next = prdata_reg;
    err_next = err_reg;
    if (psel && !penable) begin
      prdata_next = {24'h000000, rd_byte};
      err_next = !mapped;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      err_reg <= err_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = psel && penable && err_reg;

endmodule // gpio_port0_config

// file: verilog/gpio_port_pkg.sv
// Constants shared by the port-0 GPIO configuration block
package gpio_port_pkg;

  // ==========================================================
  // Configuration indices (byte address is four times these)
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_DEVICE_SELECT = 8'h07;
  localparam logic [7:0] IDX_IRQ_ROUTE = 8'h70;
  localparam logic [7:0] IDX_DIRECTION = 8'hE0;
  localparam logic [7:0] IDX_OUT_VALUE = 8'hE1;
  localparam logic [7:0] IDX_PIN_LEVEL = 8'hE2;
  localparam logic [7:0] IDX_PULSE_MODE = 8'hE3;
  localparam logic [7:0] IDX_WIDTH_LO = 8'hE4;
  localparam logic [7:0] IDX_WIDTH_HI = 8'hE5;
  localparam logic [7:0] IDX_POLARITY = 8'hE6;
  localparam logic [7:0] IDX_CHANGE_IEN = 8'hE8;
  localparam logic [7:0] IDX_CHANGE_FLAG = 8'hE9;
  localparam logic [7:0] IDX_DONE_STATUS = 8'hF0;
  localparam logic [7:0] IDX_DONE_ENABLE = 8'hF1;
  localparam logic [7:0] IDX_DONE_CLEAR = 8'hF2;

  // ==========================================================
  // Logical device selector codes
  localparam logic [7:0] DEV_FLOPPY = 8'h00;
  localparam logic [7:0] DEV_SERIAL1 = 8'h01;
  localparam logic [7:0] DEV_SERIAL2 = 8'h02;
  localparam logic [7:0] DEV_PARALLEL = 8'h03;
  localparam logic [7:0] DEV_MONITOR = 8'h04;
  localparam logic [7:0] DEV_GPIO = 8'h06;
  localparam logic [7:0] DEV_POWER_EVENT = 8'h0A;
  localparam int unsigned BANK_N = 7;

  // ==========================================================
  // Reset values and field layout
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ROUTE_MASK = 8'h0F;
  localparam int unsigned ROUTE_W = 4;
  localparam int unsigned PIN_N = 8;
  localparam int unsigned WSEL_W = 2;
  localparam int unsigned PINS_PER_WREG = 4;

  // ==========================================================
  // Pulse widths and the clock
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PW_500US_NS = 500_000;
  localparam int unsigned PW_1MS_NS = 1_000_000;
  localparam int unsigned PW_20MS_NS = 20_000_000;
  localparam int unsigned PW_100MS_NS = 100_000_000;
  localparam int unsigned PW_500US_CYC =
    (PW_500US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_1MS_CYC =
    (PW_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_20MS_CYC =
    (PW_20MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_100MS_CYC =
    (PW_100MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_CNT_W = 21;

endpackage

// file: verilog/pulse_timer.sv
// One-shot pulse timer for a single GPIO pin
`timescale 1ns/1ps

module pulse_timer #(
  parameter int unsigned CNT_W = 21
) (
  input wire logic clk, // device clock
  input wire logic nrst, // async reset, active low
  input wire logic start, // begin a pulse, ignored while busy
  input wire logic [CNT_W-1:0] term, // pulse length in cycles
  output logic busy, // high for exactly term cycles
  output logic done // last cycle of the pulse
);

  typedef enum logic {IDLE, RUN} timer_state_t;

  timer_state_t state_reg, state_next;
  logic [CNT_W-1:0] count_reg, count_next;

  initial begin
    if (CNT_W < 2) $error("pulse_timer: CNT_W too small");
  end

  // ==========================================================
  // Counter
  assign busy = (state_reg == RUN);
  assign done = (state_reg == RUN) && (count_reg == term - 1'b1);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      IDLE: begin
        // Trigger only taken while idle
        if (start) begin
          state_next = RUN;
          count_next = '0;
        end
      end
      RUN: begin
        if (done) begin
          state_next = IDLE;
        end else begin
          count_next = count_reg + 1'b1;
        end
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= IDLE;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

endmodule // pulse_timer
